// >>> pocs_pkg.sv
// Purpose : shared constants and types for the power-on configuration sequencer
// Assumes : 50 MHz system clock, supply detectors delivered as level inputs
// Notes   : all times in ns, cycle counts derived from the clock period

package pocs_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 20;
  // configuration load time, longest figure, in ns
  localparam int unsigned CFG_LOAD_TIME_NS    = 450000;
  localparam int unsigned CFG_LOAD_MIN_NS     = 200000;
  // delay from last io bank powered to user mode, in ns
  localparam int unsigned IO_GATE_TIME_NS     = 2000;
  // longest times round down
  localparam int unsigned CFG_LOAD_CYCLES     = CFG_LOAD_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned IO_GATE_CYCLES      = IO_GATE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W               = 20;

  // ---------------------------------------------------------------------------
  // reset values and variants
  // ---------------------------------------------------------------------------
  localparam logic        VARIANT_STANDARD    = 1'b0;
  localparam logic        VARIANT_ULTRA_LOW   = 1'b1;
  localparam int unsigned NUM_IO_BANKS        = 4;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_LOAD,
    ST_WAIT_IO,
    ST_IO_GATE,
    ST_CLEAR,
    ST_USER,
    ST_LOCKED
  } pocs_state_t;

  // pin control handed to the io ring
  typedef struct packed {
    logic force_tristate;
    logic weak_pullup;
    logic reg_clear;
  } pocs_pin_ctl_t;

endpackage : pocs_pkg

// >>> pocs_sync.sv
// Purpose : two flip-flop synchroniser for a vector of level inputs
// Assumes : inputs are quasi-static levels from analog detectors or pins
// Notes   : first stage is read only by the second stage

module pocs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb
  begin
    meta_d = d;
    q_d    = meta_q;
    if (!rst_n)
    begin
      meta_d = '0;
      q_d    = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    q      <= q_d;
  end

endmodule : pocs_sync

// >>> pocs_timer.sv
// Purpose : loadable down counter for load-time and io gating delays
// Assumes : start is a one-cycle pulse; count of zero means one cycle
// Notes   : done is a level while the count has expired and no restart

module pocs_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;
  logic         run_d;
  logic         done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = done;
    if (!rst_n || abort)
    begin
      cnt_d  = '0;
      run_d  = 1'b0;
      done_d = 1'b0;
    end
    else if (start)
    begin
      cnt_d  = load_val;
      run_d  = 1'b1;
      done_d = 1'b0;
    end
    else if (run_q)
    begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
      begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_d;
    run_q <= run_d;
    done  <= done_d;
  end

endmodule : pocs_timer

// >>> pocs_sequencer.sv
// Purpose : power-on reset and configuration sequencer
// Assumes : supply detectors are level inputs from outside the clock domain
// Notes   : clock stands in for the internal free-running oscillator

module pocs_sequencer #(
  parameter int unsigned NUM_BANKS       = pocs_pkg::NUM_IO_BANKS,
  parameter logic        VARIANT         = pocs_pkg::VARIANT_STANDARD,
  parameter int unsigned CFG_LOAD_CYCLES = pocs_pkg::CFG_LOAD_CYCLES,
  parameter int unsigned IO_GATE_CYCLES  = pocs_pkg::IO_GATE_CYCLES
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RESET_N,
  input  wire logic                 CORE_START_OK,
  input  wire logic                 CORE_ABOVE_BROWNOUT,
  input  wire logic                 CORE_AT_ZERO,
  input  wire logic [NUM_BANKS-1:0] IO_BANK_SUPPLY_OK,
  input  wire logic                 GLOBAL_CLEAR_EN,
  input  wire logic                 GLOBAL_REGISTER_CLEAR_INPUT_N,
  input  wire logic                 GLOBAL_OE_EN,
  input  wire logic                 GLOBAL_OUTPUT_ENABLE_INPUT,
  output pocs_pkg::pocs_pin_ctl_t   PIN_CTL,
  output logic                      SRAM_RESET,
  output logic                      CONFIG_LOAD_ACTIVE,
  output logic                      CONFIG_LOAD_DONE,
  output logic                      USER_MODE
);

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  localparam int unsigned SW = NUM_BANKS + 5;

  logic [SW-1:0]        sync_in;
  logic [SW-1:0]        sync_out;
  logic                 core_start_ok;
  logic                 core_above_bo;
  logic                 core_at_zero;
  logic [NUM_BANKS-1:0] io_ok;
  logic                 gclr_n;
  logic                 goe;

  assign sync_in = {GLOBAL_OUTPUT_ENABLE_INPUT, GLOBAL_REGISTER_CLEAR_INPUT_N,
                    CORE_AT_ZERO, CORE_ABOVE_BROWNOUT, CORE_START_OK,
                    IO_BANK_SUPPLY_OK};

  pocs_sync #(
    .W     (SW)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .d     (sync_in),
    .q     (sync_out)
  );

  assign io_ok         = sync_out[NUM_BANKS-1:0];
  assign core_start_ok = sync_out[NUM_BANKS];
  assign core_above_bo = sync_out[NUM_BANKS+1];
  assign core_at_zero  = sync_out[NUM_BANKS+2];
  assign gclr_n        = sync_out[NUM_BANKS+3];
  assign goe           = sync_out[NUM_BANKS+4];

  // ---------------------------------------------------------------------------
  // delay timers
  // ---------------------------------------------------------------------------
  localparam logic [pocs_pkg::CNT_W-1:0] LOAD_VAL = pocs_pkg::CNT_W'(CFG_LOAD_CYCLES);
  localparam logic [pocs_pkg::CNT_W-1:0] GATE_VAL = pocs_pkg::CNT_W'(IO_GATE_CYCLES);

  pocs_pkg::pocs_state_t state_q;
  pocs_pkg::pocs_state_t state_d;
  logic                  load_start;
  logic                  gate_start;
  logic                  timer_abort;
  logic                  load_done;
  logic                  gate_done;
  logic                  all_io_ok;
  logic                  cfg_done_q;
  logic                  cfg_done_d;
  logic                  zero_seen_q;
  logic                  zero_seen_d;

  pocs_timer #(
    .W        (pocs_pkg::CNT_W)
  ) u_load_timer (
    .clk      (CLOCK),
    .rst_n    (RESET_N),
    .start    (load_start),
    .abort    (timer_abort),
    .load_val (LOAD_VAL),
    .done     (load_done)
  );

  pocs_timer #(
    .W        (pocs_pkg::CNT_W)
  ) u_gate_timer (
    .clk      (CLOCK),
    .rst_n    (RESET_N),
    .start    (gate_start),
    .abort    (timer_abort),
    .load_val (GATE_VAL),
    .done     (gate_done)
  );

  assign all_io_ok = &io_ok;

  // ---------------------------------------------------------------------------
  // sequencing state machine
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d     = state_q;
    cfg_done_d  = cfg_done_q;
    zero_seen_d = zero_seen_q;
    load_start  = 1'b0;
    gate_start  = 1'b0;
    timer_abort = 1'b0;
    unique case (state_q)
      pocs_pkg::ST_OFF:
      begin
        cfg_done_d = 1'b0;
        if (core_start_ok)
        begin
          load_start = 1'b1;
          state_d    = pocs_pkg::ST_LOAD;
        end
      end
      pocs_pkg::ST_LOAD:
      begin
        if (load_done)
        begin
          cfg_done_d = 1'b1;
          // simultaneous supplies: enter within load time
          if (all_io_ok)
          begin
            state_d = pocs_pkg::ST_CLEAR;
          end
          else
          begin
            state_d = pocs_pkg::ST_WAIT_IO;
          end
        end
      end
      pocs_pkg::ST_WAIT_IO:
      begin
        // late banks start the gate delay
        if (all_io_ok)
        begin
          gate_start = 1'b1;
          state_d    = pocs_pkg::ST_IO_GATE;
        end
      end
      pocs_pkg::ST_IO_GATE:
      begin
        // a bank dropping restarts the wait
        if (!all_io_ok)
        begin
          timer_abort = 1'b1;
          state_d     = pocs_pkg::ST_WAIT_IO;
        end
        else if (gate_done)
        begin
          state_d = pocs_pkg::ST_CLEAR;
        end
      end
      pocs_pkg::ST_CLEAR:
      begin
        // one cycle with register clear released before pins go live
        state_d = pocs_pkg::ST_USER;
      end
      pocs_pkg::ST_USER:
      begin
        if (VARIANT == pocs_pkg::VARIANT_STANDARD)
        begin
          if (!core_above_bo)
          begin
            timer_abort = 1'b1;
            cfg_done_d  = 1'b0;
            state_d     = pocs_pkg::ST_OFF;
          end
        end
        else
        begin
          zero_seen_d = 1'b0;
          state_d     = pocs_pkg::ST_LOCKED;
        end
      end
      pocs_pkg::ST_LOCKED:
      begin
        // only a full core collapse re-arms
        if (core_at_zero)
        begin
          zero_seen_d = 1'b1;
        end
        if (zero_seen_q && core_start_ok)
        begin
          timer_abort = 1'b1;
          cfg_done_d  = 1'b0;
          zero_seen_d = 1'b0;
          state_d     = pocs_pkg::ST_OFF;
        end
      end
      default:
      begin
        state_d = pocs_pkg::ST_OFF;
      end
    endcase
    // standard variant: brown-out before user mode also restarts
    if (VARIANT == pocs_pkg::VARIANT_STANDARD && state_q != pocs_pkg::ST_OFF
        && state_q != pocs_pkg::ST_USER && !core_above_bo)
    begin
      timer_abort = 1'b1;
      cfg_done_d  = 1'b0;
      state_d     = pocs_pkg::ST_OFF;
    end
    if (!RESET_N)
    begin
      state_d     = pocs_pkg::ST_OFF;
      cfg_done_d  = 1'b0;
      zero_seen_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    state_q     <= state_d;
    cfg_done_q  <= cfg_done_d;
    zero_seen_q <= zero_seen_d;
  end

  // ---------------------------------------------------------------------------
  // pin and register control outputs
  // ---------------------------------------------------------------------------
  pocs_pkg::pocs_pin_ctl_t pin_d;
  logic                    sram_reset_d;
  logic                    load_active_d;
  logic                    user_d;
  logic                    in_user;

  assign in_user = (state_d == pocs_pkg::ST_USER) || (state_d == pocs_pkg::ST_LOCKED);

  always_comb
  begin
    // pins tri-stated with pull-up until user mode
    pin_d.force_tristate = 1'b1;
    pin_d.weak_pullup    = 1'b1;
    pin_d.reg_clear      = 1'b1;
    sram_reset_d         = (state_d == pocs_pkg::ST_OFF);
    load_active_d        = (state_d == pocs_pkg::ST_LOAD);
    user_d               = in_user;
    if (in_user)
    begin
      pin_d.force_tristate = 1'b0;
      pin_d.weak_pullup    = 1'b0;
      pin_d.reg_clear      = 1'b0;
      if (GLOBAL_CLEAR_EN && !gclr_n)
      begin
        pin_d.reg_clear = 1'b1;
      end
      if (GLOBAL_OE_EN && !goe)
      begin
        pin_d.force_tristate = 1'b1;
      end
    end
    else if (state_d == pocs_pkg::ST_CLEAR)
    begin
      pin_d.reg_clear = GLOBAL_CLEAR_EN && !gclr_n;
    end
    if (!RESET_N)
    begin
      pin_d.force_tristate = 1'b1;
      pin_d.weak_pullup    = 1'b1;
      pin_d.reg_clear      = 1'b1;
      sram_reset_d         = 1'b1;
      load_active_d        = 1'b0;
      user_d               = 1'b0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    PIN_CTL            <= pin_d;
    SRAM_RESET         <= sram_reset_d;
    CONFIG_LOAD_ACTIVE <= load_active_d;
    CONFIG_LOAD_DONE   <= cfg_done_d;
    USER_MODE          <= user_d;
  end

endmodule : pocs_sequencer

// >>> pocs_chk.sv
// Purpose: port-level property checks for the power-on configuration sequencer
// Assumes: bound to every sequencer instance, parameters handed on
// Notes  : detector inputs reach the state about three edges late

module pocs_chk #(
  parameter logic        VARIANT         = 1'b0,
  parameter int unsigned NUM_BANKS       = 4,
  parameter int unsigned CFG_LOAD_CYCLES = 20
) (
  input wire logic                    CLOCK,
  input wire logic                    RESET_N,
  input wire logic                    CORE_START_OK,
  input wire logic                    CORE_ABOVE_BROWNOUT,
  input wire logic                    CORE_AT_ZERO,
  input wire logic [NUM_BANKS-1:0]    IO_BANK_SUPPLY_OK,
  input wire logic                    GLOBAL_CLEAR_EN,
  input wire logic                    GLOBAL_OE_EN,
  input wire logic                    GLOBAL_OUTPUT_ENABLE_INPUT,
  input wire pocs_pkg::pocs_pin_ctl_t PIN_CTL,
  input wire logic                    SRAM_RESET,
  input wire logic                    CONFIG_LOAD_ACTIVE,
  input wire logic                    CONFIG_LOAD_DONE,
  input wire logic                    USER_MODE
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // load length counter
  // ---------------------------------------------------------------
  logic [19:0] load_cnt_q;
  logic [19:0] load_cnt_d;

  always_comb load_cnt_d = CONFIG_LOAD_ACTIVE ? load_cnt_q + 20'h00001 : 20'h00000;
  always_ff @(posedge CLOCK) load_cnt_q <= RESET_N ? load_cnt_d : 20'h00000;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  a_tristate_idle: assert property (!USER_MODE |-> PIN_CTL.force_tristate)
    else $error("pins released outside user mode");
  a_load_pullup: assert property (CONFIG_LOAD_ACTIVE |-> PIN_CTL.force_tristate && PIN_CTL.weak_pullup)
    else $error("pins not held with pull-up during load");
  a_load_start: assert property ((SRAM_RESET && CORE_ABOVE_BROWNOUT && CORE_START_OK) [*3]
    |-> ##[0:2] CONFIG_LOAD_ACTIVE) else $error("load did not start at threshold");
  a_load_length: assert property ($fell(CONFIG_LOAD_ACTIVE) && CONFIG_LOAD_DONE
    |-> load_cnt_q >= CFG_LOAD_CYCLES && load_cnt_q <= CFG_LOAD_CYCLES + 3)
    else $error("load length off");
  a_bank_gate: assert property ($rose(USER_MODE) |-> &$past(IO_BANK_SUPPLY_OK, 4))
    else $error("user mode without all banks");
  a_brownout_reset: assert property ((VARIANT == 1'b0 && !CORE_ABOVE_BROWNOUT) [*3]
    |-> ##[0:2] (SRAM_RESET && PIN_CTL.force_tristate && !USER_MODE))
    else $error("sag did not reset");
  a_ulp_no_watch: assert property (VARIANT == 1'b1 && USER_MODE && !CORE_ABOVE_BROWNOUT
    && !CORE_AT_ZERO && !$past(CORE_AT_ZERO) && !$past(CORE_AT_ZERO, 2) |=> USER_MODE)
    else $error("low power variant left user mode on sag");
  a_clear_first: assert property ($fell(PIN_CTL.force_tristate) && !GLOBAL_CLEAR_EN
    |-> !$past(PIN_CTL.reg_clear)) else $error("clear released after pins");
  a_oe_hold: assert property ((GLOBAL_OE_EN && !GLOBAL_OUTPUT_ENABLE_INPUT) [*4]
    |-> PIN_CTL.force_tristate) else $error("pins released against output enable");

  c_user: cover property ($rose(USER_MODE));
  c_sag: cover property (USER_MODE && !CORE_ABOVE_BROWNOUT);
  c_oe_held: cover property (USER_MODE && PIN_CTL.force_tristate);
endmodule : pocs_chk

// >>> pocs_supply_model.sv
// Purpose: board supplies as seen by the sequencer's detectors
// Assumes: core level moves by a set step each cycle, in mV
// Notes  : bank supplies switch at once

module pocs_supply_model #(
  parameter logic [11:0] START_MV = 12'h6a4,
  parameter logic [11:0] SAG_MV   = 12'h578
) (
  input  wire logic        clk,
  input  wire logic [11:0] core_set_mv,
  input  wire logic [11:0] step_mv,
  input  wire logic [3:0]  bank_on,
  output logic             core_start_ok,
  output logic             core_above_sag,
  output logic             core_zero,
  output logic [3:0]       bank_ok
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] core_q;

  initial core_q = 12'h000;
  always @(posedge clk)
  begin
    if (core_q + step_mv <= core_set_mv)
      core_q <= core_q + step_mv;
    else if (core_q >= core_set_mv + step_mv)
      core_q <= core_q - step_mv;
    else
      core_q <= core_set_mv;
  end
  assign core_start_ok  = core_q >= START_MV;
  assign core_above_sag = core_q > SAG_MV;
  assign core_zero      = core_q == 12'h000;
  assign bank_ok        = bank_on;
endmodule : pocs_supply_model

// >>> tb_top.sv
// Purpose: self-checking bench for the power-on configuration sequencer
// Assumes: short load and gate counts, both variants fed by one supply model
// Notes  : inputs change by non-blocking assignment at the rising edge

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned CFG  = 20;
  localparam int unsigned GATE = 5;

  logic                    CLOCK;
  logic                    RESET_N;
  logic [11:0]             core_set;
  logic [11:0]             step;
  logic [3:0]              bank_on;
  wire                     start_ok, above_sag, core_zero;
  wire  [3:0]              bank_ok;
  logic                    clr_en, clr_n, oe_en, oe_pin;
  wire pocs_pkg::pocs_pin_ctl_t pin [2];
  wire  [1:0]              sram, load, done, user;
  wire  [6:0]              obs = {core_zero, load, sram[0], done[0], user};
  int                      errors;
  int                      checks_done;
  int                      n;

  pocs_supply_model pocs_supply_model_inst (.clk(CLOCK), .core_set_mv(core_set),
    .step_mv(step), .bank_on(bank_on), .core_start_ok(start_ok),
    .core_above_sag(above_sag), .core_zero(core_zero), .bank_ok(bank_ok));

  for (genvar g = 0; g < 2; g++)
  begin : g_var
    pocs_sequencer #(.VARIANT(g == 1 ? pocs_pkg::VARIANT_ULTRA_LOW : pocs_pkg::VARIANT_STANDARD),
      .CFG_LOAD_CYCLES(CFG), .IO_GATE_CYCLES(GATE)) pocs_sequencer_inst (
      .CLOCK(CLOCK), .RESET_N(RESET_N), .CORE_START_OK(start_ok),
      .CORE_ABOVE_BROWNOUT(above_sag), .CORE_AT_ZERO(core_zero), .IO_BANK_SUPPLY_OK(bank_ok),
      .GLOBAL_CLEAR_EN(clr_en), .GLOBAL_REGISTER_CLEAR_INPUT_N(clr_n), .GLOBAL_OE_EN(oe_en),
      .GLOBAL_OUTPUT_ENABLE_INPUT(oe_pin), .PIN_CTL(pin[g]), .SRAM_RESET(sram[g]),
      .CONFIG_LOAD_ACTIVE(load[g]), .CONFIG_LOAD_DONE(done[g]), .USER_MODE(user[g]));
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check

  task automatic wait_hi(input int sel, input int lim, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge CLOCK);
      #1;
      cyc++;
    end
    while (cyc < lim && obs[sel] !== 1'b1);
    if (obs[sel] !== 1'b1)
    begin
      errors++;
      $display("Error at %0t: wait on %0d ran out", $time, sel);
      tally_and_finish();
    end
  endtask : wait_hi

  task automatic supply(input logic [11:0] mv, input logic [3:0] banks);
    @(posedge CLOCK);
    core_set <= mv;
    bank_on  <= banks;
  endtask : supply

  task automatic cycle_power(input logic [3:0] banks);
    supply(12'h000, banks);
    wait_hi(6, 40, n);
    repeat (4) @(posedge CLOCK);
    supply(12'hce4, banks);
  endtask : cycle_power

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up;
    supply(12'hce4, 4'hf);
    wait_hi(4, 40, n);
    check({sram[0], load[0]}, 2'b01);
    check(pin[0], 3'b111);
    check(pin[1], 3'b111);
    wait_hi(0, CFG + 10, n);
    check(n >= CFG, 1'b1);
    check({pin[0].force_tristate, pin[0].reg_clear}, 2'b00);
    wait_hi(1, 4, n);
    $display("power-up done");
  endtask : t_power_up

  task automatic t_brownout;
    step <= 12'h032;
    supply(12'h3e8, 4'hf);
    wait_hi(3, 80, n);
    check({pin[0].force_tristate, user[0]}, 2'b10);
    check(user[1], 1'b1);
    supply(12'hce4, 4'hf);
    wait_hi(4, 40, n);
    wait_hi(0, CFG + 10, n);
    check(n >= CFG, 1'b1);
    check(user[1], 1'b1);
    step <= 12'h0c8;
    $display("brown-out done");
  endtask : t_brownout

  task automatic t_zero_restart;
    cycle_power(4'hf);
    wait_hi(5, 40, n);
    wait_hi(1, CFG + 10, n);
    check(n >= CFG, 1'b1);
    $display("zero restart done");
  endtask : t_zero_restart

  task automatic t_late_banks;
    cycle_power(4'h0);
    wait_hi(2, CFG + 30, n);
    repeat (GATE * 3) @(posedge CLOCK);
    supply(12'hce4, 4'h7);
    repeat (GATE * 3) @(posedge CLOCK);
    #1;
    check(user, 2'b00);
    supply(12'hce4, 4'hf);
    wait_hi(0, GATE + 12, n);
    check(n >= GATE, 1'b1);
    check(pin[0].reg_clear, 1'b0);
    $display("late banks done");
  endtask : t_late_banks

  task automatic t_global_pins;
    @(posedge CLOCK);
    clr_en <= 1'b1;
    oe_en  <= 1'b1;
    clr_n  <= 1'b0;
    oe_pin <= 1'b0;
    cycle_power(4'hf);
    wait_hi(0, CFG + 30, n);
    repeat (GATE) @(posedge CLOCK);
    #1;
    check({pin[0].force_tristate, pin[0].reg_clear}, 2'b11);
    @(posedge CLOCK);
    oe_pin <= 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    check({pin[0].force_tristate, pin[0].reg_clear}, 2'b01);
    @(posedge CLOCK);
    clr_n <= 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    check(pin[0].reg_clear, 1'b0);
    $display("global pins done");
  endtask : t_global_pins

  task automatic t_mid_reset;
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    repeat (4) @(posedge CLOCK);
    #1;
    check(pin[1], 3'b111);
    check({sram[0], user}, 3'b100);
    @(posedge CLOCK);
    RESET_N <= 1'b1;
    wait_hi(4, 10, n);
    check(sram[0], 1'b0);
    wait_hi(0, CFG + 10, n);
    check(n >= CFG, 1'b1);
    $display("mid-run reset done");
  endtask : t_mid_reset

  initial
  begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  initial
  begin
    errors      = 0;
    checks_done = 0;
    RESET_N     = 1'b0;
    core_set    = 12'h000;
    step        = 12'h0c8;
    bank_on     = 4'h0;
    clr_en      = 1'b0;
    clr_n       = 1'b1;
    oe_en       = 1'b0;
    oe_pin      = 1'b1;
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
    t_power_up();
    t_brownout();
    t_zero_restart();
    t_late_banks();
    t_global_pins();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : tb_top

bind pocs_sequencer pocs_chk #(.VARIANT(VARIANT), .NUM_BANKS(NUM_BANKS),
  .CFG_LOAD_CYCLES(CFG_LOAD_CYCLES)) pocs_chk_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .CORE_START_OK(CORE_START_OK), .CORE_ABOVE_BROWNOUT(CORE_ABOVE_BROWNOUT),
  .CORE_AT_ZERO(CORE_AT_ZERO), .IO_BANK_SUPPLY_OK(IO_BANK_SUPPLY_OK),
  .GLOBAL_CLEAR_EN(GLOBAL_CLEAR_EN), .GLOBAL_OE_EN(GLOBAL_OE_EN),
  .GLOBAL_OUTPUT_ENABLE_INPUT(GLOBAL_OUTPUT_ENABLE_INPUT), .PIN_CTL(PIN_CTL),
  .SRAM_RESET(SRAM_RESET), .CONFIG_LOAD_ACTIVE(CONFIG_LOAD_ACTIVE),
  .CONFIG_LOAD_DONE(CONFIG_LOAD_DONE), .USER_MODE(USER_MODE));
